// ==== src/rpl_defines.vh ====
// constants for the received power and control/status register logic
// assumes a two-wire serial host and a converter that runs on clk
// Functional notes
// - received power reads as a read-only high byte at 104 and low byte at 105, both zero after reset.
// - with external calibration the raw 12-bit converter value sits left-aligned with the low four bits zero.
// - control bit 7 is read-only and follows the transmit-disable pin, 1 meaning disabled.
// - control bit 6 is a soft transmit disable ORed with the pin, and the laser is off if either is 1.
// - control bit 5 is read-only and mirrors the second rate-select pin, 1 meaning above 4.25 Gbps.
// - control bit 4 is read-only and mirrors the first rate-select pin.
// - control bit 3 is a soft rate select that drives the first rate-select output rate_sel_a_drive high or low.
// - control bit 2 is read-only and mirrors the transmit-fault pin.
// - control bit 1 is read-only and mirrors the receiver loss-of-signal pin.
// - control bit 0 reads 1 during reset and the first converter cycle, then 0 once all inputs were converted.
`ifndef RPL_DEFINES_VH
`define RPL_DEFINES_VH
`define RPL_DEV_ADDR 7'h51
`define RPL_OFS_RX_MSB 8'h68
`define RPL_OFS_RX_LSB 8'h69
`define RPL_OFS_CTRL 8'h6E
`define RPL_RST_BYTE 8'h00
`define RPL_BIT_PIN_PIN_TX_DISABLE_STATE 7
`define RPL_BIT_SOFT_PIN_TX_DISABLE_STATE 6
`define RPL_BIT_RS_B 5
`define RPL_BIT_RS_A 4
`define RPL_BIT_SOFT_RS 3
`define RPL_BIT_TX_FAULT_STATE 2
`define RPL_BIT_LOS 1
`define RPL_BIT_POR 0
`define RPL_BYTE_BITS 4'h8
`define RPL_SLOPE_FRAC 8
`endif

// ==== src/rpl_rx_power.v ====
// received power result builder: external or internal calibration
// assumes converter strobes are synchronous to clk
`include "rpl_defines.vh"
module rpl_rx_power (
  input wire clk,
  input wire reset,
  input wire cal_internal,
  input wire adc_valid,
  input wire [11:0] adc_data,
  input wire adc_cycle_done,
  input wire coeff_wr,
  input wire [2:0] coeff_idx,
  input wire [15:0] coeff_slope,
  input wire [15:0] coeff_offset,
  input wire [2:0] coeff_sel,
  output reg [15:0] rx_power,
  output reg por_busy
);
  reg [15:0] rx_power_slope_coeff [0:7];
  reg [15:0] rx_power_offset_coeff [0:7];
  reg [15:0] sample;
  reg [27:0] product;
  reg [16:0] sum;
  reg [15:0] next_sample;

  always @(posedge clk) begin
    if (coeff_wr) begin
      rx_power_slope_coeff[coeff_idx] <= coeff_slope;
      rx_power_offset_coeff[coeff_idx] <= coeff_offset;
    end
  end

  // slope is 8.8 fixed point; the sum saturates rather than wrapping
  always @* begin
    product = adc_data * rx_power_slope_coeff[coeff_sel];
    sum = {1'b0, product[23:8]} + {1'b0, rx_power_offset_coeff[coeff_sel]};
    if (cal_internal) begin
      next_sample = (sum[16] || product[27:24] != 4'h0) ? 16'hFFFF : sum[15:0];
    end else begin
      next_sample = {adc_data, 4'h0};
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      sample <= 16'h0000;
      rx_power <= 16'h0000;
      por_busy <= 1'b1;
    end else begin
      if (adc_valid) begin
        sample <= next_sample;
      end
      if (adc_cycle_done) begin
        por_busy <= 1'b0;
      end
      // publishing only at cycle ends keeps the two bytes from one conversion
      if (adc_cycle_done) begin
        rx_power <= adc_valid ? next_sample : sample;
      end
    end
  end
endmodule // rpl_rx_power

// ==== src/rpl_regs.v ====
// two-wire serial slave holding the received power and control/status bytes
// assumes scl and sda arrive asynchronously; sda is open drain, pulled high outside
`include "rpl_defines.vh"
module rpl_regs (
  input wire clk,
  input wire reset,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire tx_disable_pin,
  input wire rate_sel_a_pin,
  input wire rate_sel_b_pin,
  input wire tx_fault_pin,
  input wire rx_signal_lost_pin,
  output reg laser_off,
  output reg rate_sel_a_drive,
  input wire cal_internal,
  input wire adc_valid,
  input wire [11:0] adc_data,
  input wire adc_cycle_done,
  input wire coeff_wr,
  input wire [2:0] coeff_idx,
  input wire [15:0] coeff_slope,
  input wire [15:0] coeff_offset,
  input wire [2:0] coeff_sel
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_ACK = 6'h04;
  localparam [5:0] S_WR = 6'h08;
  localparam [5:0] S_RD = 6'h10;
  localparam [5:0] S_MACK = 6'h20;

  reg [2:0] scl_q;
  reg [2:0] sda_q;
  reg [4:0] pin_m;
  reg [4:0] pin_s;
  reg [5:0] state;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg [7:0] ptr;
  reg ptr_phase;
  reg is_read;
  reg soft_tx_disable;
  reg soft_rate_sel_a;
  wire [15:0] rx_power;
  wire por_busy;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire pin_tx_disable_state;
  wire rate_sel_a_state;
  wire rate_sel_b_state;
  wire tx_fault_state;
  wire signal_lost_state;
  wire [7:0] control_and_pin_status;
  wire [7:0] tx_byte;

  rpl_rx_power u_rx_power (
    .clk(clk),
    .reset(reset),
    .cal_internal(cal_internal),
    .adc_valid(adc_valid),
    .adc_data(adc_data),
    .adc_cycle_done(adc_cycle_done),
    .coeff_wr(coeff_wr),
    .coeff_idx(coeff_idx),
    .coeff_slope(coeff_slope),
    .coeff_offset(coeff_offset),
    .coeff_sel(coeff_sel),
    .rx_power(rx_power),
    .por_busy(por_busy)
  );

  // stage 0 feeds only stage 1; edges are found between stages 1 and 2
  always @(posedge clk) begin
    if (reset) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      pin_m <= 5'h00;
      pin_s <= 5'h00;
    end else begin
      scl_q <= {scl_q[1:0], scl};
      sda_q <= {sda_q[1:0], sda_in};
      pin_m <= {tx_disable_pin, rate_sel_b_pin, rate_sel_a_pin, tx_fault_pin, rx_signal_lost_pin};
      pin_s <= pin_m;
    end
  end

  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_cond = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_cond = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  assign pin_tx_disable_state = pin_s[4];
  assign rate_sel_b_state = pin_s[3];
  assign rate_sel_a_state = pin_s[2];
  assign tx_fault_state = pin_s[1];
  assign signal_lost_state = pin_s[0];

  assign control_and_pin_status = {pin_tx_disable_state,
                                   soft_tx_disable,
                                   rate_sel_b_state,
                                   rate_sel_a_state,
                                   soft_rate_sel_a,
                                   tx_fault_state,
                                   signal_lost_state,
                                   por_busy};

  function [7:0] read_byte;
    input [7:0] addr;
    input [15:0] rxp;
    input [7:0] ctrl;
    begin
      if (addr == `RPL_OFS_RX_MSB) begin
        read_byte = rxp[15:8];
      end else if (addr == `RPL_OFS_RX_LSB) begin
        read_byte = rxp[7:0];
      end else if (addr == `RPL_OFS_CTRL) begin
        read_byte = ctrl;
      end else begin
        read_byte = 8'h00;
      end
    end
  endfunction

  assign tx_byte = read_byte(ptr, rx_power, control_and_pin_status);

  always @(posedge clk) begin
    if (reset) begin
      state <= S_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      ptr <= 8'h00;
      ptr_phase <= 1'b1;
      is_read <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      soft_tx_disable <= 1'b0;
      soft_rate_sel_a <= 1'b0;
      laser_off <= 1'b0;
      rate_sel_a_drive <= 1'b0;
    end else begin
      laser_off <= pin_tx_disable_state | soft_tx_disable;
      rate_sel_a_drive <= soft_rate_sel_a;
      if (start_cond) begin
        state <= S_ADDR;
        bitcnt <= 4'h0;
        ptr_phase <= 1'b1;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          S_ADDR, S_WR: begin
            shreg <= {shreg[6:0], sda_q[1]};
            bitcnt <= bitcnt + 4'h1;
          end
          S_MACK: begin
            // a not-acknowledge ends the read burst
            state <= sda_q[1] ? S_IDLE : S_ACK;
          end
          default: begin
            state <= state;
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          S_ADDR: begin
            if (bitcnt == `RPL_BYTE_BITS) begin
              if (shreg[7:1] == `RPL_DEV_ADDR) begin
                is_read <= shreg[0];
                sda_oe <= 1'b1;
                state <= S_ACK;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_WR: begin
            if (bitcnt == `RPL_BYTE_BITS) begin
              if (ptr_phase) begin
                ptr <= shreg;
                ptr_phase <= 1'b0;
              end else begin
                if (ptr == `RPL_OFS_CTRL) begin
                  soft_tx_disable <= shreg[`RPL_BIT_SOFT_PIN_TX_DISABLE_STATE];
                  soft_rate_sel_a <= shreg[`RPL_BIT_SOFT_RS];
                end
                ptr <= ptr + 8'h01;
              end
              sda_oe <= 1'b1;
              state <= S_ACK;
            end
          end
          S_ACK: begin
            if (is_read) begin
              sda_oe <= ~tx_byte[7];
              shreg <= {tx_byte[6:0], 1'b0};
              bitcnt <= 4'h1;
              ptr <= ptr + 8'h01;
              state <= S_RD;
            end else begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              state <= S_WR;
            end
          end
          S_RD: begin
            if (bitcnt == `RPL_BYTE_BITS) begin
              sda_oe <= 1'b0;
              state <= S_MACK;
            end else begin
              sda_oe <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end
endmodule // rpl_regs

// ==== tb/rpl_regs_sva.sv ====
// checker on rpl_regs ports: serial drive timing, laser and rate outputs
// assumes one clk domain with synchronous active-high reset
module rpl_regs_sva (
  input wire clk,
  input wire reset,
  input wire scl,
  input wire sda_out,
  input wire sda_oe,
  input wire tx_disable_pin,
  input wire laser_off,
  input wire rate_sel_a_drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_outs_low: assert property ($fell(reset) |-> !sda_oe && !laser_off && !rate_sel_a_drive)
    else $error("outputs not low after reset");
  a_laser_pin_on: assert property (tx_disable_pin [*4] |-> laser_off)
    else $error("laser on with pin high");
  a_laser_rise_why: assert property ($rose(laser_off) && !$past(tx_disable_pin, 3) |-> !$past(scl))
    else $error("laser off without cause");
  a_laser_fall_why: assert property ($fell(laser_off) |-> !$past(tx_disable_pin, 3))
    else $error("laser on with pin high");
  a_rate_on_write: assert property ($changed(rate_sel_a_drive) |-> !$past(scl) && !$past(scl, 2))
    else $error("rate drive moved off a write");
  a_sda_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("sda moved with scl high");
  a_sda_bit_holds: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("sda bit too short");
  c_laser: cover property ($rose(laser_off));
  c_rate: cover property ($rose(rate_sel_a_drive));
  c_ack: cover property ($rose(sda_oe));
endmodule // rpl_regs_sva
bind rpl_regs rpl_regs_sva chk (.clk(clk), .reset(reset), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
  .tx_disable_pin(tx_disable_pin), .laser_off(laser_off), .rate_sel_a_drive(rate_sel_a_drive));

// ==== tb/rpl_host.sv ====
// serial host model: start, stop, byte writes and burst reads
// assumes a pulled-up sda wire; calls begin on a falling clk edge
`include "rpl_defines.vh"
module rpl_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_data;
  event rd_ev;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // scl runs at 64 ns; data moves mid low phase, the slave answers about 20 ns after a fall
  task automatic bitx(input logic b, output logic r);
    #16 sda_low = !b;
    #16 scl = 1'b1;
    r = sda;
    #32 scl = 1'b0;
  endtask
  task automatic start;
    #16 sda_low = 1'b0;
    #16 scl = 1'b1;
    #16 sda_low = 1'b1;
    #16 scl = 1'b0;
  endtask
  task automatic bytex(input logic [7:0] d, input logic last, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(last, k);
  endtask
  // n of 0 writes d at ofs, otherwise reads n bytes from ofs
  task automatic xfer(input logic [7:0] ofs, input logic [7:0] d, input int n, output logic nak);
    logic [7:0] q;
    logic k0, k1;
    start;
    bytex({`RPL_DEV_ADDR, 1'b0}, 1'b1, q, k0);
    bytex(ofs, 1'b1, q, k1);
    if (n == 0)
      bytex(d, 1'b1, q, nak);
    else begin
      start;
      bytex({`RPL_DEV_ADDR, 1'b1}, 1'b1, q, nak);
      for (int i = 1; i <= n; i++) begin
        bytex(8'hFF, i == n, rd_data, q[0]);
        -> rd_ev;
      end
    end
    #16 sda_low = 1'b1;
    #16 scl = 1'b1;
    #16 sda_low = 1'b0;
    nak = nak | k0 | k1;
  endtask
endmodule // rpl_host

// ==== tb/testbench.sv ====
// bench for rpl_regs: pins and converter driven here, serial traffic through rpl_host
// assumes rpl_defines.vh on the include path
`include "rpl_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic tx_disable_pin, rate_sel_a_pin, rate_sel_b_pin, tx_fault_pin, rx_signal_lost_pin, cal_internal;
  logic adc_valid, adc_cycle_done, coeff_wr, scl, host_low, sda_out, sda_oe, laser_off, rate_sel_a_drive, nak;
  logic [11:0] adc_data;
  logic [2:0] coeff_idx, coeff_sel;
  logic [15:0] coeff_slope, coeff_offset;
  logic [31:0] seed = 32'h0D72;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // open drain: any pull low wins over the pull-up
  wire sda_in = !host_low & (!sda_oe | sda_out);
  always #4 clk = ~clk;
  rpl_regs uut (.clk, .reset, .scl, .sda_in, .sda_out, .sda_oe, .tx_disable_pin, .rate_sel_a_pin, .rate_sel_b_pin,
    .tx_fault_pin, .rx_signal_lost_pin, .laser_off, .rate_sel_a_drive, .cal_internal, .adc_valid, .adc_data,
    .adc_cycle_done, .coeff_wr, .coeff_idx, .coeff_slope, .coeff_offset, .coeff_sel);
  rpl_host host (.scl, .sda_low(host_low), .sda(sda_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // 8.8 slope with truncation, then offset, saturating at full scale
  function automatic logic [15:0] cal(input logic [11:0] d, input logic [15:0] s, input logic [15:0] o);
    logic [31:0] p;
    p = ((d * s) >> 8) + o;
    return p > 32'h0000FFFF ? 16'hFFFF : p[15:0];
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] ofs, input logic [15:0] e, input int n);
    if (n == 2)
      exp_q.push_back(e[15:8]);
    exp_q.push_back(e[7:0]);
    host.xfer(ofs, 8'h00, n, nak);
    @(negedge clk);
  endtask
  task automatic wrx(input logic [7:0] ofs, input logic [7:0] d);
    host.xfer(ofs, d, 0, nak);
    @(negedge clk);
    check("ack", nak, 1'b0);
  endtask
  task automatic adc(input logic [11:0] d, input logic done);
    adc_data = d;
    adc_valid = 1'b1;
    @(negedge clk);
    adc_valid = 1'b0;
    adc_cycle_done = done;
    @(negedge clk);
    adc_cycle_done = 1'b0;
  endtask
  always @(host.rd_ev)
    check("read", host.rd_data, exp_q.pop_front());
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    {tx_disable_pin, rate_sel_a_pin, rate_sel_b_pin, tx_fault_pin, rx_signal_lost_pin} = 5'h00;
    {cal_internal, adc_valid, adc_cycle_done, coeff_wr} = 4'h0;
    {adc_data, coeff_idx, coeff_sel, coeff_slope, coeff_offset} = 50'h0;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    wrx(`RPL_OFS_RX_MSB, 8'hFF);
    rdx(`RPL_OFS_RX_MSB, 16'h0000, 2);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      {tx_disable_pin, rate_sel_b_pin, rate_sel_a_pin, tx_fault_pin, rx_signal_lost_pin} = seed[4:0];
      repeat (4) @(negedge clk);
      check("laser_off", laser_off, seed[4]);
      rdx(`RPL_OFS_CTRL, {seed[4], 1'b0, seed[3:2], 1'b0, seed[1:0], 1'b1}, 1);
    end
    {tx_disable_pin, rate_sel_b_pin, rate_sel_a_pin, tx_fault_pin, rx_signal_lost_pin} = 5'h00;
    wrx(`RPL_OFS_CTRL, 8'hFF);
    rdx(`RPL_OFS_CTRL, 16'h0049, 1);
    check("laser_off", laser_off, 1'b1);
    check("rate_drive", rate_sel_a_drive, 1'b1);
    wrx(`RPL_OFS_CTRL, 8'h00);
    check("laser_off", laser_off, 1'b0);
    check("rate_drive", rate_sel_a_drive, 1'b0);
    seed = lfsr(seed);
    adc(seed[11:0], 1'b0);
    rdx(`RPL_OFS_RX_MSB, 16'h0000, 2);
    adc(seed[11:0], 1'b1);
    rdx(`RPL_OFS_RX_MSB, {seed[11:0], 4'h0}, 2);
    rdx(`RPL_OFS_CTRL, 16'h0000, 1);
    rdx(8'h70, 16'h0000, 1);
    coeff_wr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      coeff_idx = i[2:0];
      coeff_slope = {i[2:0], 13'h0040};
      coeff_offset = {i[3:0], 12'h010};
      @(negedge clk);
    end
    coeff_wr = 1'b0;
    cal_internal = 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      coeff_sel = i[2:0];
      adc(seed[11:0], 1'b1);
      rdx(`RPL_OFS_RX_MSB, cal(seed[11:0], {i[2:0], 13'h0040}, {i[3:0], 12'h010}), 2);
    end
    // a second reset must drop the published result and raise the power-on flag again
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    rdx(`RPL_OFS_RX_MSB, 16'h0000, 2);
    rdx(`RPL_OFS_CTRL, 16'h0001, 1);
    print_verdict;
  end
endmodule // testbench
